// ---- core/amgp_pin_routing.sv ----
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module amgp_pin_routing
  import amgp_pkg::*;
#(
  parameter int WS_HALF_BITS = WS_HALF_BITS_D
) (
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // audio clocks
  output logic             audio_bit_clock_out,
  output logic             audio_word_select_out,
  // audio lane pins, lanes 0-7 first unit, 8-15 second unit
  input  wire logic [15:0] serial_audio_in_lane_i,
  output logic      [15:0] serial_audio_in_lane_o,
  output logic      [15:0] serial_audio_in_lane_oe,
  output logic      [15:0] serial_audio_out_lane,
  // midi pins
  input  wire logic        first_midi_receive_pin,
  output logic             first_midi_transmit_pin,
  input  wire logic        second_midi_receive_pin_i,
  output logic             second_midi_receive_pin_o,
  output logic             second_midi_receive_pin_oe,
  output logic             second_midi_transmit_pin,
  // processing unit side
  input  wire logic [7:0]  unit1_audio_out,
  input  wire logic [7:0]  unit2_audio_out,
  output logic      [7:0]  unit1_audio_in,
  output logic      [7:0]  unit2_audio_in,
  output logic             audio_in_strobe,
  output logic             audio_out_strobe,
  input  wire logic        unit1_midi_tx,
  input  wire logic        unit2_midi_tx,
  output logic             unit1_midi_rx,
  output logic             unit2_midi_rx
);

  localparam int WSW = (WS_HALF_BITS > 1) ? $clog2(WS_HALF_BITS) : 1;

  logic [3:0]     bck_cnt;
  logic [WSW-1:0] ws_cnt;
  logic           fall_en;
  logic           sample_en;
  logic [15:0]    in_sync;
  logic [1:0]     midi_sync;
  logic [15:0]    aud_hold;
  logic           midi_share;
  logic [7:0]     route;
  logic [7:0]     u1_sel, u1_dir, u1_out;
  logic [7:0]     u2_sel, u2_dir, u2_out;
  logic [3:0]     u1_gpi, u2_gpi;
  logic [15:0]    out_gp_en, out_gp_val;
  logic [15:0]    in_gp_oe, in_gp_val;
  logic [3:0]     next_u1_gpi, next_u2_gpi;
  logic           wr_ph, rd_ph1;
  logic [7:0]     addr_q;
  logic [31:0]    next_rdata;

  amgp_sync #(.W(16)) u_sync_lanes (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (serial_audio_in_lane_i),
    .q       (in_sync)
  );

  amgp_sync #(.W(2), .RST_VAL('1)) u_sync_midi ( // idle high, no false start
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({second_midi_receive_pin_i, first_midi_receive_pin}),
    .q       (midi_sync)
  );

  // bit clock and word select from one divider
  assign fall_en          = (bck_cnt == BCK_FALL);
  assign sample_en        = (bck_cnt == IN_SAMPLE);
  assign audio_out_strobe = fall_en & audio_bit_clock_out;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bck_cnt             <= 4'h0;
      audio_bit_clock_out <= 1'b0;
    end else begin
      bck_cnt <= bck_cnt + 4'h1;
      if (bck_cnt == BCK_LAST) begin
        audio_bit_clock_out <= 1'b1;
      end else if (fall_en) begin
        audio_bit_clock_out <= 1'b0;
      end
    end
  end

  // word select moves with the falling edge, mid-period of the bit clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ws_cnt                <= '0;
      audio_word_select_out <= 1'b0;
    end else if (fall_en) begin
      if (ws_cnt == WSW'(WS_HALF_BITS - 1)) begin
        ws_cnt                <= '0;
        audio_word_select_out <= ~audio_word_select_out;
      end else begin
        ws_cnt <= ws_cnt + WSW'(1);
      end
    end
  end

  // unit outputs are taken at the fall so pins settle mid-period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aud_hold <= 16'h0000;
    end else if (audio_out_strobe) begin
      aud_hold <= {unit2_audio_out, unit1_audio_out};
    end
  end

  // 20-bit slots are the source's duty; lanes are passed bit by bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit1_audio_in  <= 8'h00;
      unit2_audio_in  <= 8'h00;
      audio_in_strobe <= 1'b0;
    end else begin
      audio_in_strobe <= sample_en & audio_bit_clock_out;
      if (sample_en && audio_bit_clock_out) begin
        unit1_audio_in <= (route & aud_hold[15:8])
                        | (~route & in_sync[7:0]);
        unit2_audio_in <= in_sync[15:8];
      end
    end
  end

  // general-purpose pin map
  always_comb begin
    out_gp_en  = 16'h0000;
    out_gp_val = 16'h0000;
    in_gp_oe   = 16'h0000;
    in_gp_val  = 16'h0000;
    for (int i = 0; i < U1_OUT_LANE_CNT; i++) begin
      out_gp_en[U1_OUT_LANE_FIRST+i]  = u1_sel[U1_GPO_OUT_LANE+i];
      out_gp_val[U1_OUT_LANE_FIRST+i] = u1_out[U1_GPO_OUT_LANE+i];
    end
    for (int i = 0; i < U2_OUT_LANE_CNT; i++) begin
      out_gp_en[U2_OUT_LANE_FIRST+i]  = u2_sel[U2_GPO_OUT_LANE+i];
      out_gp_val[U2_OUT_LANE_FIRST+i] = u2_out[U2_GPO_OUT_LANE+i];
    end
    for (int i = 0; i < U1_IN_LANE_CNT; i++) begin
      in_gp_oe[U1_IN_LANE_FIRST+i]  = u1_sel[U1_GPO_IN_LANE+i]
                                    & u1_dir[U1_GPO_IN_LANE+i];
      in_gp_val[U1_IN_LANE_FIRST+i] = u1_out[U1_GPO_IN_LANE+i];
    end
    for (int i = 0; i < U2_IN_LANE_CNT; i++) begin
      in_gp_oe[U2_IN_LANE_FIRST+i]  = u2_sel[U2_GPO_IN_LANE+i]
                                    & u2_dir[U2_GPO_IN_LANE+i];
      in_gp_val[U2_IN_LANE_FIRST+i] = u2_out[U2_GPO_IN_LANE+i];
    end
  end

  always_comb begin
    next_u1_gpi    = 4'h0;
    next_u2_gpi    = 4'h0;
    for (int i = 0; i < U1_IN_LANE_CNT; i++) begin
      next_u1_gpi[i] = in_sync[U1_IN_LANE_FIRST+i];
    end
    // free whenever shared; still readable otherwise
    next_u2_gpi[0] = midi_sync[1];
    for (int i = 0; i < U2_IN_LANE_CNT; i++) begin
      next_u2_gpi[1+i] = in_sync[U2_IN_LANE_FIRST+i];
    end
  end

  // pin drivers, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_audio_out_lane   <= 16'h0000;
      serial_audio_in_lane_o  <= 16'h0000;
      serial_audio_in_lane_oe <= 16'h0000;
      u1_gpi                  <= 4'h0;
      u2_gpi                  <= 4'h1; // midi pin idles high
    end else begin
      serial_audio_out_lane   <= (out_gp_en & out_gp_val)
                               | (~out_gp_en & aud_hold);
      serial_audio_in_lane_o  <= in_gp_val;
      serial_audio_in_lane_oe <= in_gp_oe;
      u1_gpi                  <= next_u1_gpi;
      u2_gpi                  <= next_u2_gpi;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit1_midi_rx              <= 1'b1;
      unit2_midi_rx              <= 1'b1;
      first_midi_transmit_pin    <= 1'b1;
      second_midi_transmit_pin   <= 1'b1;
      second_midi_receive_pin_o  <= 1'b0;
      second_midi_receive_pin_oe <= 1'b0;
    end else begin
      unit1_midi_rx           <= midi_sync[0];
      unit2_midi_rx           <= midi_share ? midi_sync[0]
                                            : midi_sync[1];
      first_midi_transmit_pin <= unit1_midi_tx;
      second_midi_transmit_pin <= u1_sel[U1_GPO_MIDI2_TX]
                                ? u1_out[U1_GPO_MIDI2_TX]
                                : unit2_midi_tx;
      second_midi_receive_pin_o  <= u2_out[U2_GPO_MIDI2_RX];
      second_midi_receive_pin_oe <= u2_sel[U2_GPO_MIDI2_RX]
                                  & u2_dir[U2_GPO_MIDI2_RX];
    end
  end

  // ahb-lite: writes in one data cycle, reads take one wait state
  assign hreadyout = ~rd_ph1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph  <= 1'b0;
      rd_ph1 <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      rd_ph1 <= 1'b0;
      if (hready) begin
        wr_ph  <= hsel & htrans[1] & hwrite;
        rd_ph1 <= hsel & htrans[1] & ~hwrite;
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // unmapped offsets read zero and ignore writes
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (addr_q)
      REG_CTRL:   next_rdata[CTRL_SHARE_BIT] = midi_share;
      REG_ROUTE:  next_rdata[7:0] = route;
      REG_U1_SEL: next_rdata[7:0] = u1_sel;
      REG_U1_DIR: next_rdata[7:0] = u1_dir;
      REG_U1_OUT: next_rdata[7:0] = u1_out;
      REG_U1_IN:  next_rdata[3:0] = u1_gpi;
      REG_U2_SEL: next_rdata[7:0] = u2_sel;
      REG_U2_DIR: next_rdata[7:0] = u2_dir;
      REG_U2_OUT: next_rdata[7:0] = u2_out;
      REG_U2_IN:  next_rdata[3:0] = u2_gpi;
      REG_STATUS: begin
        next_rdata[STAT_BCK_BIT] = audio_bit_clock_out;
        next_rdata[STAT_WS_BIT]  = audio_word_select_out;
      end
      default:    next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_ph1) begin
      hrdata <= next_rdata;
    end
  end

  // configuration applies on the next edge, no reset needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      midi_share <= 1'b0;
      route      <= CFG_RESET;
      u1_sel     <= CFG_RESET;
      u1_dir     <= CFG_RESET;
      u1_out     <= CFG_RESET;
      u2_sel     <= CFG_RESET;
      u2_dir     <= CFG_RESET;
      u2_out     <= CFG_RESET;
    end else if (wr_ph) begin
      case (addr_q)
        REG_CTRL:   midi_share <= hwdata[CTRL_SHARE_BIT];
        REG_ROUTE:  route      <= hwdata[7:0];
        REG_U1_SEL: u1_sel     <= hwdata[7:0];
        REG_U1_DIR: u1_dir     <= hwdata[7:0];
        REG_U1_OUT: u1_out     <= hwdata[7:0];
        REG_U2_SEL: u2_sel     <= hwdata[7:0];
        REG_U2_DIR: u2_dir     <= hwdata[7:0];
        REG_U2_OUT: u2_out     <= hwdata[7:0];
        default:    route      <= route;
      endcase
    end
  end

  property p_bck_period;
    @(posedge hclk) disable iff (!hresetn)
      $rose(audio_bit_clock_out) |-> ##16 $rose(audio_bit_clock_out);
  endproperty
  a_bck_period: assert property (p_bck_period)
    else $error("bit clock period is not sixteen cycles");

  property p_ws_mid;
    @(posedge hclk) disable iff (!hresetn)
      $changed(audio_word_select_out) |->
        $fell(audio_bit_clock_out) && $past(audio_bit_clock_out, 8)
        && !$past(audio_bit_clock_out, 9);
  endproperty
  a_ws_mid: assert property (p_ws_mid)
    else $error("word select changed away from mid-period");

  property p_out_hold;
    @(posedge hclk) disable iff (!hresetn)
      $changed(aud_hold) |-> $fell(audio_bit_clock_out);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("audio output data changed outside the bit clock fall");

  property p_in_sample;
    @(posedge hclk) disable iff (!hresetn)
      audio_in_strobe |-> audio_bit_clock_out
        && $past(audio_bit_clock_out, 2) && !$past(audio_bit_clock_out, 3);
  endproperty
  a_in_sample: assert property (p_in_sample)
    else $error("input strobe not tied to the bit clock rise");

  property p_route;
    @(posedge hclk) disable iff (!hresetn)
      audio_in_strobe |-> unit1_audio_in ==
        (($past(route) & $past(aud_hold[15:8]))
        | (~$past(route) & $past(in_sync[7:0])));
  endproperty
  a_route: assert property (p_route)
    else $error("unit one input routing wrong");

  property p_midi_rx;
    @(posedge hclk) disable iff (!hresetn)
      $past(midi_share) |-> unit2_midi_rx == $past(midi_sync[0])
        && unit1_midi_rx == $past(midi_sync[0]);
  endproperty
  a_midi_rx: assert property (p_midi_rx)
    else $error("shared midi receive not seen by both units");

  property p_midi_dflt;
    @(posedge hclk) disable iff (!hresetn)
      !$past(midi_share) |-> unit2_midi_rx == $past(midi_sync[1])
        && first_midi_transmit_pin == $past(unit1_midi_tx);
  endproperty
  a_midi_dflt: assert property (p_midi_dflt)
    else $error("default midi assignment wrong");

  property p_gpo_tx;
    @(posedge hclk) disable iff (!hresetn)
      $past(u1_sel[U1_GPO_MIDI2_TX]) |->
        second_midi_transmit_pin == $past(u1_out[U1_GPO_MIDI2_TX]);
  endproperty
  a_gpo_tx: assert property (p_gpo_tx)
    else $error("second midi transmit pin not driven by gp output");

  property p_gpo_rx_pin;
    @(posedge hclk) disable iff (!hresetn)
      $past(u2_sel[U2_GPO_MIDI2_RX] & u2_dir[U2_GPO_MIDI2_RX]) |->
        second_midi_receive_pin_oe
        && second_midi_receive_pin_o == $past(u2_out[U2_GPO_MIDI2_RX]);
  endproperty
  a_gpo_rx_pin: assert property (p_gpo_rx_pin)
    else $error("second midi receive pin gp drive wrong");

  property p_gpi;
    @(posedge hclk) disable iff (!hresetn)
      ##1 u1_gpi == $past(in_sync[3:0]) && u2_gpi[0] == $past(midi_sync[1]);
  endproperty
  a_gpi: assert property (p_gpi)
    else $error("gp input bits do not follow the pins");

  property p_cfg_write;
    @(posedge hclk) disable iff (!hresetn)
      wr_ph && addr_q == REG_ROUTE |=> route == $past(hwdata[7:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("routing register write not taken");

endmodule : amgp_pin_routing

// ---- core/amgp_pkg.sv ----
// How it works
// - each unit has eight serial audio input and eight output lanes, sixteen each.
// - each unit-two audio output can feed the matching unit-one audio input.
// - by default MIDI port one serves unit one, MIDI port two unit two.
// - shared setting feeds the first MIDI receive pin to both units.
// - while shared, the second MIDI receive pin is free as general input.
// - second MIDI transmit pin may be used as a general-purpose output.
// - each eligible pin selects normal or general-purpose use on its own.
// - unit-one output bits 0-7: MIDI2 transmit, out lanes 1-3, in lanes 0-3.
// - unit-two output bits 0-7: out lanes 4-7, MIDI2 receive, in lanes 5-7.
// - unit-one input bits 0-3 read audio input lanes 0-3.
// - unit-two input bits read MIDI2 receive pin, then in lanes 5-7.
// - audio bit clock period is sixteen master clock cycles.
// - word select changes eight cycles after the bit clock rises.
// - lane data stable eight cycles around bit clock rise; inputs sampled there.
package amgp_pkg;

  // bit clock divider, counts in master clock cycles
  localparam int          BCK_PERIOD_CYC = 16;
  localparam logic [3:0]  BCK_LAST       = 4'hf;
  localparam logic [3:0]  BCK_FALL       = 4'h7;
  // two synchroniser stages after the rise: samples the pin level at the rise
  localparam logic [3:0]  IN_SAMPLE      = 4'h1;
  localparam int          WS_HALF_BITS_D = 32;
  localparam int          LANES          = 8;

  // register byte offsets
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_ROUTE  = 8'h04;
  localparam logic [7:0]  REG_U1_SEL = 8'h08;
  localparam logic [7:0]  REG_U1_DIR = 8'h0c;
  localparam logic [7:0]  REG_U1_OUT = 8'h10;
  localparam logic [7:0]  REG_U1_IN  = 8'h14;
  localparam logic [7:0]  REG_U2_SEL = 8'h18;
  localparam logic [7:0]  REG_U2_DIR = 8'h1c;
  localparam logic [7:0]  REG_U2_OUT = 8'h20;
  localparam logic [7:0]  REG_U2_IN  = 8'h24;
  localparam logic [7:0]  REG_STATUS = 8'h28;

  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam int          CTRL_SHARE_BIT  = 0;
  localparam int          STAT_BCK_BIT    = 0;
  localparam int          STAT_WS_BIT     = 1;

  // general-purpose bit to pin map
  localparam int U1_GPO_MIDI2_TX   = 0;
  localparam int U1_GPO_OUT_LANE   = 1;
  localparam int U1_OUT_LANE_FIRST = 1;
  localparam int U1_OUT_LANE_CNT   = 3;
  localparam int U1_GPO_IN_LANE    = 4;
  localparam int U1_IN_LANE_FIRST  = 0;
  localparam int U1_IN_LANE_CNT    = 4;
  localparam int U2_GPO_OUT_LANE   = 0;
  localparam int U2_OUT_LANE_FIRST = 4;
  localparam int U2_OUT_LANE_CNT   = 4;
  localparam int U2_GPO_MIDI2_RX   = 4;
  localparam int U2_GPO_IN_LANE    = 5;
  localparam int U2_IN_LANE_FIRST  = 5;
  localparam int U2_IN_LANE_CNT    = 3;

endpackage : amgp_pkg

// ---- core/amgp_sync.sv ----
`timescale 1ns/1ps
module amgp_sync #(
  parameter int           W       = 1,
  // level held through reset, the idle level of the pin
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // level to bring in, and its synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : amgp_sync

// ---- testbench/amgp_codec_model.sv ----
`timescale 1ns/1ps
module amgp_codec_model (
  // clocks from the device
  input  wire logic        audio_bit_clock_out,
  input  wire logic        audio_word_select_out,
  // audio lanes
  input  wire logic [15:0] serial_audio_out_lane,
  output logic      [15:0] lane_drive,
  output logic      [15:0] lane_sent,
  output logic      [15:0] lane_got,
  // hold the input lanes at a fixed level for pin reads
  input  wire logic        freeze,
  input  wire logic [15:0] freeze_val
);
  logic ws_seen;
  int   bit_idx;

  initial begin
    lane_drive = 16'h0000;
    lane_sent  = 16'h0000;
    lane_got   = 16'h0000;
    ws_seen    = 1'b0;
    bit_idx    = 0;
  end

  // new data only after the fall, so it sits still across each rise
  always @(negedge audio_bit_clock_out) begin
    #1;
    if (audio_word_select_out !== ws_seen) begin
      bit_idx = 0;
    end else begin
      bit_idx = bit_idx + 1;
    end
    ws_seen = audio_word_select_out;
    for (int i = 0; i < 16; i++) begin
      logic [19:0] smp;
      smp = 20'h5a3c9 ^ {5{4'(i)}};
      // twenty data bits per slot, the rest of the slot is zero
      lane_drive[i] = freeze ? freeze_val[i] :
                      (bit_idx < 20 ? smp[19 - bit_idx] : 1'b0);
    end
  end

  always @(posedge audio_bit_clock_out) begin
    lane_sent <= lane_drive;
    lane_got  <= serial_audio_out_lane;
  end
endmodule : amgp_codec_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import amgp_pkg::*;
  localparam int         WS_HALF = 4;
  localparam logic [7:0] RTS [3] = '{8'h00, 8'h5a, 8'hff};
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, bck, ws, m2_o, m2_oe, m2_wire;
  logic [15:0] lane_wire, lane_o, lane_oe, lane_drv, lane_sent, lane_got;
  logic [15:0] out_lane;
  logic [15:0] frz_val = 16'h00a5;
  logic        m1 = 1'b1, m2 = 1'b1, tx1 = 1'b1, tx2 = 1'b1;
  logic        freeze = 1'b0, chk_aud = 1'b0, bck_d = 1'b0, ws_d = 1'b0;
  logic        mtx1, mtx2, urx1, urx2, in_stb, out_stb;
  logic [7:0]  u1_out = 8'h00, u2_out = 8'h00, route_v = 8'h00;
  logic [7:0]  u1_in, u2_in;
  int          err_total = 0, checks_done = 0, since = 0, since_ws = 0;
  int          per_cyc = 0, ws_after = 0, ws_gap = 0;

  always #2 hclk = ~hclk;
  // pin level is the design's drive where enabled, else the far side's
  assign lane_wire = (lane_oe & lane_o) | (~lane_oe & lane_drv);
  assign m2_wire   = m2_oe ? m2_o : m2;

  amgp_pin_routing #(.WS_HALF_BITS(WS_HALF)) i_amgp_pin_routing (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .audio_bit_clock_out(bck), .audio_word_select_out(ws),
    .serial_audio_in_lane_i(lane_wire), .serial_audio_in_lane_o(lane_o),
    .serial_audio_in_lane_oe(lane_oe), .serial_audio_out_lane(out_lane),
    .first_midi_receive_pin(m1), .first_midi_transmit_pin(mtx1),
    .second_midi_receive_pin_i(m2_wire), .second_midi_receive_pin_o(m2_o),
    .second_midi_receive_pin_oe(m2_oe), .second_midi_transmit_pin(mtx2),
    .unit1_audio_out(u1_out), .unit2_audio_out(u2_out),
    .unit1_audio_in(u1_in), .unit2_audio_in(u2_in),
    .audio_in_strobe(in_stb), .audio_out_strobe(out_stb),
    .unit1_midi_tx(tx1), .unit2_midi_tx(tx2),
    .unit1_midi_rx(urx1), .unit2_midi_rx(urx2)
  );

  amgp_codec_model i_amgp_codec_model (
    .audio_bit_clock_out(bck), .audio_word_select_out(ws),
    .serial_audio_out_lane(out_lane), .lane_drive(lane_drv),
    .lane_sent(lane_sent), .lane_got(lane_got),
    .freeze(freeze), .freeze_val(frz_val)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // hready is read right after each rising edge, i.e. as that edge saw it
  task automatic ahb(input logic wr, input logic [7:0] adr,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, adr};
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    ahb(1'b0, adr, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : rd_chk

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // cycle counts between bit clock rises and word select changes
  always @(posedge hclk) begin
    bck_d    <= bck;
    ws_d     <= ws;
    since    <= (bck && !bck_d) ? 1 : since + 1;
    since_ws <= (ws !== ws_d) ? 1 : since_ws + 1;
    if (bck && !bck_d) begin
      per_cyc <= since;
    end
    if (ws !== ws_d) begin
      ws_after <= since;
      ws_gap   <= since_ws;
    end
    // unit outputs are taken only in the last high cycle of the bit clock
    if (out_stb === 1'b1) begin
      check({31'h0, bck}, 32'h1);
    end
    if (in_stb === 1'b1 && chk_aud) begin
      check({24'h0, u1_in},
            {24'h0, (route_v & u2_out) | (~route_v & lane_sent[7:0])});
      check({24'h0, u2_in}, {24'h0, lane_sent[15:8]});
      check({16'h0, lane_got}, {16'h0, u2_out, u1_out});
    end
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 11; i++) begin
      if (i != 5 && i != 9) begin
        rd_chk(8'(i * 4), 32'h0);
      end
    end
    ahb(1'b1, 8'h2c, 32'hffff_ffff);
    rd_chk(8'h2c, 32'h0);
    repeat (200) @(posedge hclk);
    check(per_cyc, 16);
    check(ws_after, 8);
    check(ws_gap, WS_HALF * 16);
    u1_out <= 8'ha6;
    u2_out <= 8'h3c;
    for (int k = 0; k < 3; k++) begin
      chk_aud <= 1'b0;
      route_v <= RTS[k];
      ahb(1'b1, REG_ROUTE, {24'h0, RTS[k]});
      repeat (40) @(posedge hclk);
      chk_aud <= 1'b1;
      repeat (100) @(posedge hclk);
    end
    chk_aud <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      {m1, m2, tx1, tx2} <= (k == 1) ? 4'b1001 : 4'b0110;
      repeat (8) @(posedge hclk);
      check(urx1, m1);
      check(urx2, m2);
      check(mtx1, tx1);
      check(mtx2, tx2);
    end
    freeze <= 1'b1;
    ahb(1'b1, REG_CTRL, 32'h1);
    m1 <= 1'b0;
    m2 <= 1'b1;
    repeat (40) @(posedge hclk);
    check(urx2, m1);
    check(urx1, m1);
    rd_chk(REG_U1_IN, 32'h5);
    rd_chk(REG_U2_IN, {28'h0, frz_val[7:5], m2});
    ahb(1'b1, REG_U1_SEL, 32'hff);
    ahb(1'b1, REG_U1_DIR, 32'hf0);
    ahb(1'b1, REG_U1_OUT, 32'h96);
    ahb(1'b1, REG_U2_SEL, 32'hff);
    ahb(1'b1, REG_U2_DIR, 32'hf0);
    ahb(1'b1, REG_U2_OUT, 32'h6b);
    repeat (8) @(posedge hclk);
    check(mtx2, 1'b0);
    check(out_lane[3:0], {3'b011, u1_out[0]});
    check(out_lane[7:4], 4'hb);
    check({lane_oe, lane_o & lane_oe}, {16'h00ef, 16'h0069});
    check({m2_oe, m2_o}, 2'b10);
    rd_chk(REG_U1_IN, 32'h9);
    rd_chk(REG_U2_IN, 32'h6);
    rd_chk(REG_U1_OUT, 32'h96);
    wrap_up;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    err_total++;
    wrap_up;
  end
endmodule : tb_top
